// ===== design/efs_pkg.sv
// Package for the extended fault status word: command codes, field
// positions, reset values and the carrier types of the command port.
// Assumes a PMBus engine on the same clock decodes frames into commands.
package efs_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EFS_CODE_STATUS       = 8'hF3;
  localparam logic [7:0] EFS_CODE_CLEAR_FAULTS = 8'h03;

  // ----------------------------------------------------------------
  // Field positions of the status word
  // ----------------------------------------------------------------
  localparam int EFS_WORD_W          = 16;
  localparam int EFS_FLAG_W          = 14;
  localparam int EFS_BIT_PGOOD_LOW   = 13;
  localparam int EFS_BIT_SINGLE_PT   = 12;
  localparam int EFS_BIT_SHORT       = 11;
  localparam int EFS_BIT_OVERCURRENT = 10;
  localparam int EFS_BIT_EIN_OVF     = 9;
  localparam int EFS_BIT_IN_SURGE    = 8;
  localparam int EFS_BIT_EE_PRESENT  = 7;
  localparam int EFS_BIT_EE_WRITTEN  = 6;
  localparam int EFS_BIT_AVERAGED    = 5;
  localparam int EFS_BIT_CABLE       = 4;
  localparam int EFS_BIT_RETRY_RCVD  = 3;
  localparam int EFS_BIT_PCYCLE_REC  = 2;
  localparam int EFS_BIT_INIT_DONE   = 1;
  localparam int EFS_BIT_NVM_BUSY    = 0;
  localparam logic [1:0] EFS_RSVD_VALUE = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [EFS_FLAG_W-1:0] EFS_FLAGS_RESET = 14'h0000;
  localparam logic [EFS_WORD_W-1:0] EFS_DATA_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EFS_KIND_SEND_BYTE  = 2'h0,
    EFS_KIND_WRITE_WORD = 2'h1,
    EFS_KIND_READ_WORD  = 2'h2,
    EFS_KIND_READ_BYTE  = 2'h3
  } efs_kind_t;

  typedef enum logic [1:0] {
    EFS_ST_IDLE   = 2'h0,
    EFS_ST_ANSWER = 2'h1
  } efs_state_t;

  // Raw detector causes, bit 13 first
  typedef struct packed {
    logic power_good_low_flag;
    logic single_point_failure_flag;
    logic short_circuit_flag;
    logic overcurrent_detect_flag;
    logic energy_accumulator_overflow_flag;
    logic input_transient_flag;
    logic eeprom_present_flag;
    logic eeprom_written_flag;
    logic averaging_complete_flag;
    logic input_cable_fault_flag;
    logic auto_retry_recovered_flag;
    logic power_cycle_recovered_flag;
    logic init_done_flag;
    logic nvm_busy_flag;
  } efs_causes_t;

  typedef struct packed {
    logic             valid;
    efs_kind_t        kind;
    logic [7:0]       code;
    logic [15:0]      wdata;
  } efs_cmd_t;

  typedef struct packed {
    logic             valid;
    logic             ack;
    logic [15:0]      rdata;
  } efs_rsp_t;

endpackage : efs_pkg

// ===== design/efs_flag_bank.sv
// Bank of sticky status flags with input synchronisers.
// Assumes causes are levels from detectors outside this clock domain.
`timescale 1ns/1ns
`default_nettype none

module efs_flag_bank
  import efs_pkg::*;
#(
  parameter int                W          = EFS_FLAG_W,
  parameter logic [W-1:0]      RESET_VAL  = EFS_FLAGS_RESET
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [W-1:0]    cause_raw,
  input  wire logic            clear,
  output logic      [W-1:0]    cause_live,
  output logic      [W-1:0]    flags_q
);

  // ----------------------------------------------------------------
  // Per-bit synchroniser and sticky latch
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    logic flag_d;

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= cause_raw[i];
        sync_q <= meta_q;
      end
    end

    // Set wins over clear; clear only drops a bit whose cause is gone
    always_comb begin
      flag_d = sync_q | (flags_q[i] & ~clear);
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        flags_q[i] <= RESET_VAL[i];
      end else begin
        flags_q[i] <= flag_d;
      end
    end

    assign cause_live[i] = sync_q;
  end

endmodule : efs_flag_bank

`default_nettype wire

// ===== design/efs_status_word.sv
// Extended fault status word answering read-word command F3h.
// Assumes a PMBus frame engine on the same clock hands over decoded
// commands and serialises the answer word, low byte first.
`timescale 1ns/1ns
`default_nettype none

module efs_status_word
  import efs_pkg::*;
#(
  parameter logic [7:0] STATUS_CODE = EFS_CODE_STATUS,
  parameter logic [7:0] CLEAR_CODE  = EFS_CODE_CLEAR_FAULTS
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire efs_causes_t       causes,
  input  wire efs_cmd_t          cmd,
  output logic                   cmd_ready,
  output efs_rsp_t               rsp,
  output logic [EFS_WORD_W-1:0]  extended_fault_status,
  output logic                   clear_seen
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  efs_state_t                    state_q;
  efs_state_t                    state_d;
  logic                          take;
  logic                          is_status;
  logic                          is_read_word;
  logic                          is_clear;
  logic                          clear_pulse;
  logic                          ack_d;
  logic                          ack_q;
  logic [EFS_WORD_W-1:0]         rdata_q;
  logic [EFS_WORD_W-1:0]         word_now;
  logic [EFS_FLAG_W-1:0]         flags_q;
  logic [EFS_FLAG_W-1:0]         cause_live;
  logic                          clear_seen_q;

  assign cmd_ready    = (state_q == EFS_ST_IDLE);
  assign take         = cmd.valid & cmd_ready;
  assign is_status    = (cmd.code == STATUS_CODE);
  assign is_read_word = (cmd.kind == EFS_KIND_READ_WORD);
  assign is_clear     = (cmd.code == CLEAR_CODE) && (cmd.kind == EFS_KIND_SEND_BYTE);
  assign clear_pulse  = take & is_clear;

  // Read-word on the status code and send-byte on the clear code are the only accesses acknowledged
  always_comb begin
    ack_d = 1'b0;
    if (is_status && is_read_word) begin
      ack_d = 1'b1;
    end else if (is_clear) begin
      ack_d = 1'b1;
    end else begin
      ack_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  efs_flag_bank #(
    .W          (EFS_FLAG_W),
    .RESET_VAL  (EFS_FLAGS_RESET)
  ) u_flags (
    .clock      (clock),
    .rst        (rst),
    .cause_raw  (causes),
    .clear      (clear_pulse),
    .cause_live (cause_live),
    .flags_q    (flags_q)
  );

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  always_comb begin
    word_now = EFS_DATA_RESET;
    word_now[EFS_WORD_W-1:EFS_FLAG_W]   = EFS_RSVD_VALUE;
    word_now[EFS_BIT_PGOOD_LOW]         = flags_q[EFS_BIT_PGOOD_LOW];
    word_now[EFS_BIT_SINGLE_PT]         = flags_q[EFS_BIT_SINGLE_PT];
    word_now[EFS_BIT_SHORT]             = flags_q[EFS_BIT_SHORT];
    word_now[EFS_BIT_OVERCURRENT]       = flags_q[EFS_BIT_OVERCURRENT];
    word_now[EFS_BIT_EIN_OVF]           = flags_q[EFS_BIT_EIN_OVF];
    word_now[EFS_BIT_IN_SURGE]          = flags_q[EFS_BIT_IN_SURGE];
    word_now[EFS_BIT_EE_PRESENT]        = flags_q[EFS_BIT_EE_PRESENT];
    word_now[EFS_BIT_EE_WRITTEN]        = flags_q[EFS_BIT_EE_WRITTEN];
    word_now[EFS_BIT_AVERAGED]          = flags_q[EFS_BIT_AVERAGED];
    word_now[EFS_BIT_CABLE]             = flags_q[EFS_BIT_CABLE];
    word_now[EFS_BIT_RETRY_RCVD]        = flags_q[EFS_BIT_RETRY_RCVD];
    word_now[EFS_BIT_PCYCLE_REC]        = flags_q[EFS_BIT_PCYCLE_REC];
    word_now[EFS_BIT_INIT_DONE]         = flags_q[EFS_BIT_INIT_DONE];
    word_now[EFS_BIT_NVM_BUSY]          = flags_q[EFS_BIT_NVM_BUSY];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      extended_fault_status <= EFS_DATA_RESET;
    end else begin
      extended_fault_status <= word_now;
    end
  end

  // ----------------------------------------------------------------
  // Answer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      EFS_ST_IDLE: begin
        if (take) begin
          state_d = EFS_ST_ANSWER;
        end
      end
      EFS_ST_ANSWER: begin
        state_d = EFS_ST_IDLE;
      end
      default: begin
        state_d = EFS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= EFS_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Snapshot taken with the command so the word is stable for the reply
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= EFS_DATA_RESET;
      ack_q   <= 1'b0;
    end else if (take) begin
      ack_q <= ack_d;
      if (is_status && is_read_word) begin
        rdata_q <= word_now;
      end else begin
        rdata_q <= EFS_DATA_RESET;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clear_seen_q <= 1'b0;
    end else begin
      clear_seen_q <= clear_pulse;
    end
  end

  assign clear_seen = clear_seen_q;

  always_comb begin
    rsp       = '0;
    rsp.valid = (state_q == EFS_ST_ANSWER);
    rsp.ack   = ack_q;
    rsp.rdata = rdata_q;
  end

endmodule : efs_status_word

`default_nettype wire

// ===== sim/efs_status_word_sva.sv
// Checker of the status word command port and sticky flag outputs.
// Assumes the top module's ports only; attached by the bind below.
`timescale 1ns/1ns
`default_nettype none

module efs_status_word_sva
  import efs_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire efs_causes_t           causes,
  input wire efs_cmd_t              cmd,
  input wire logic                  cmd_ready,
  input wire efs_rsp_t              rsp,
  input wire logic [EFS_WORD_W-1:0] extended_fault_status,
  input wire logic                  clear_seen
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire take = cmd.valid && cmd_ready;
  wire rd_ok = take && cmd.kind == EFS_KIND_READ_WORD && cmd.code == EFS_CODE_STATUS;
  wire clr = take && cmd.kind == EFS_KIND_SEND_BYTE && cmd.code == EFS_CODE_CLEAR_FAULTS;
  wire wr = take && cmd.kind == EFS_KIND_WRITE_WORD;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RSP_AFTER_TAKE: assert property (take |=> rsp.valid ##1 !rsp.valid)
    else $error("no single response after command");
  AST_NO_RSP_IDLE: assert property (!take |=> !rsp.valid)
    else $error("response without command");
  AST_READ_ACK: assert property (rd_ok |=> rsp.ack)
    else $error("status read not acknowledged");
  AST_BUSY_ANSWER: assert property (rsp.valid |-> !cmd_ready)
    else $error("ready during answer cycle");
  AST_WRITE_NACK: assert property (wr |=> !rsp.ack && rsp.rdata == 16'h0000)
    else $error("write to status word accepted");
  AST_RSVD_ZERO: assert property (extended_fault_status[15:14] == EFS_RSVD_VALUE
                                  && rsp.rdata[15:14] == EFS_RSVD_VALUE)
    else $error("reserved bits not zero");
  AST_CLEAR_PULSE: assert property (clr |=> clear_seen ##1 !clear_seen)
    else $error("clear pulse wrong");
  AST_STICKY: assert property (!clear_seen |=>
                               ($past(extended_fault_status) & ~extended_fault_status) == 0)
    else $error("flag dropped without clear");
  AST_SHORT_SET: assert property (causes.short_circuit_flag [*4] |=>
                                  extended_fault_status[EFS_BIT_SHORT])
    else $error("short circuit flag late");
  AST_SPF_SET: assert property (causes.single_point_failure_flag [*4] |=>
                                extended_fault_status[EFS_BIT_SINGLE_PT])
    else $error("single point failure flag late");
  C_READ: cover property (rd_ok ##1 rsp.ack);
  C_CLEAR: cover property (clr ##1 clear_seen);
  C_WRITE: cover property (wr ##1 !rsp.ack);
endmodule : efs_status_word_sva

bind efs_status_word efs_status_word_sva u_sva (.clock(clock), .rst(rst), .causes(causes),
  .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp),
  .extended_fault_status(extended_fault_status), .clear_seen(clear_seen));

`default_nettype wire

// ===== sim/efs_host_model.sv
// Host controller model issuing decoded commands to the status word.
// Assumes the caller owns the clock; one transfer at a time.
`timescale 1ns/1ns
`default_nettype none

module efs_host_model
  import efs_pkg::*;
(
  input  wire logic     clock,
  output efs_cmd_t      cmd,
  input  wire logic     cmd_ready,
  input  wire efs_rsp_t rsp
);
  initial cmd = '0;
  // Request held until taken, fields idle at inverse afterwards
  task automatic xfer(input efs_kind_t k, input logic [7:0] c, input logic [15:0] w,
                      output logic [15:0] d, output logic a);
    logic r;
    int   n;
    @(posedge clock);
    cmd <= '{1'b1, k, c, w};
    do begin
      @(negedge clock);
      r = cmd_ready;
      @(posedge clock);
    end while (r !== 1'b1);
    cmd <= '{1'b0, efs_kind_t'(~k), ~c, ~w};
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp.valid !== 1'b1 && n < 8);
    d = rsp.rdata;
    a = rsp.ack;
  endtask : xfer
endmodule : efs_host_model

`default_nettype wire

// ===== sim/tb_efs_status_word.sv
// Self-checking bench of the status word: flags, clears, refusals.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module tb_efs_status_word;
  import efs_pkg::*;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  efs_causes_t causes = '0;
  efs_cmd_t    cmd;
  logic        cmd_ready;
  efs_rsp_t    rsp;
  logic [15:0] efs_word;
  logic        clear_seen;
  logic [15:0] d;
  logic        a;
  int          err_count = 0;
  int          n_checks  = 0;
  always #5 clock = ~clock;
  efs_status_word DUT (.clock(clock), .rst(rst), .causes(causes), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp(rsp), .extended_fault_status(efs_word),
    .clear_seen(clear_seen));
  efs_host_model host (.clock(clock), .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [15:0] exp);
    host.xfer(EFS_KIND_READ_WORD, EFS_CODE_STATUS, 16'h0000, d, a);
    check({15'h0000, a}, 16'h0001);
    check(d, exp);
  endtask : rd_chk
  task automatic clr_chk();
    host.xfer(EFS_KIND_SEND_BYTE, EFS_CODE_CLEAR_FAULTS, 16'h0000, d, a);
    check({15'h0000, a}, 16'h0001);
  endtask : clr_chk
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    check({15'h0000, cmd_ready}, 16'h0001);
    rd_chk(16'h0000);
    for (int b = 0; b < EFS_FLAG_W; b++) begin
      @(posedge clock);
      causes <= efs_causes_t'(14'h0001 << b);
      repeat (5) @(posedge clock);
      causes <= '0;
      repeat (5) @(posedge clock);
      rd_chk(16'h0001 << b);
      check(efs_word, 16'h0001 << b);
      clr_chk();
      rd_chk(16'h0000);
    end
    @(posedge clock);
    causes <= '1;
    repeat (5) @(posedge clock);
    clr_chk();
    rd_chk(16'h3FFF);
    host.xfer(EFS_KIND_WRITE_WORD, EFS_CODE_STATUS, 16'hFFFF, d, a);
    check({15'h0000, a}, 16'h0000);
    check(d, 16'h0000);
    @(posedge clock);
    causes <= '0;
    repeat (5) @(posedge clock);
    host.xfer(EFS_KIND_READ_BYTE, EFS_CODE_STATUS, 16'h0000, d, a);
    check({15'h0000, a}, 16'h0000);
    check(d, 16'h0000);
    host.xfer(EFS_KIND_READ_WORD, 8'h80, 16'h0000, d, a);
    check({15'h0000, a}, 16'h0000);
    check(d, 16'h0000);
    rd_chk(16'h3FFF);
    clr_chk();
    rd_chk(16'h0000);
    check(efs_word, 16'h0000);
    results();
  end
  initial begin
    repeat (6000) @(posedge clock);
    err_count++;
    results();
  end
endmodule : tb_efs_status_word

`default_nettype wire
